// [spims_core.v]
// Byte-wide serial master/slave with select-line modes and status flags
`timescale 1ns/1ns
`default_nettype none
`include "spims_regs.vh"
module spims_core #(
  parameter DIV_W = `SPIMS_DIV_W
) (
  input wire ref_clk,
  input wire rstn,
  input wire [DIV_W-1:0] clk_div,
  input wire block_enable_set,
  input wire block_enable_clr,
  input wire master_enable_set,
  input wire master_enable_clr,
  input wire [1:0] select_mode_wr,
  input wire select_mode_we,
  input wire clock_phase_bit,
  input wire clock_polarity_bit,
  input wire [7:0] wr_data,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire transfer_done_clr,
  input wire mode_fault_clr,
  input wire write_collision_clr,
  input wire receive_overrun_clr,
  output reg block_enable_bit,
  output reg master_enable_bit,
  output reg select_mode_high_bit,
  output reg select_mode_low_bit,
  output reg transfer_done_flag,
  output reg mode_fault_flag,
  output reg write_collision_flag,
  output reg receive_overrun_flag,
  output wire irq_req,
  output reg [7:0] rd_data,
  output wire busy,
  input wire sck_in,
  output reg sck_out,
  output wire sck_oe_n,
  input wire mosi_in,
  output reg mosi_out,
  output wire mosi_oe_n,
  input wire miso_in,
  output reg miso_out,
  output wire miso_oe_n,
  input wire select_line_in,
  output reg select_line_out,
  output wire select_line_oe_n
);
  reg rst1_q;
  reg rst2_q;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst1_q <= 1'b0;
      rst2_q <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst2_q <= rst1_q;
    end
  end
  wire rst_n = rst2_q;

  wire [3:0] pins_s;
  spims_sync #(.W(4)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din({sck_in, mosi_in, miso_in, select_line_in}),
    .dout(pins_s)
  );
  wire sck_s = pins_s[3];
  wire mosi_s = pins_s[2];
  wire miso_s = pins_s[1];
  wire sel_s = pins_s[0];
  reg sck_prev_q;

  reg [7:0] txbuf_q;
  reg txfull_q;
  reg [7:0] shift_q;
  reg [3:0] bitcnt_q;
  reg active_q;
  reg rxfull_q;
  reg [DIV_W-1:0] divcnt_q;
  reg half_q;
  reg last_q;
  reg fault_ev;
  localparam [DIV_W-1:0] DIV_ONE = `SPIMS_ONE_DIV;

  wire master = block_enable_bit & master_enable_bit;
  wire multi = {select_mode_high_bit, select_mode_low_bit} == `SPIMS_NSS_MULTI;
  // Divider floor keeps the bit rate at a quarter of the system clock or less
  wire [DIV_W-1:0] div_eff = (clk_div == {DIV_W{1'b0}}) ? DIV_ONE : clk_div;
  wire tick = master & active_q & (divcnt_q == {DIV_W{1'b0}});
  wire load = master & txfull_q & ~active_q;
  wire mstr_lead = tick & ~half_q;
  wire mstr_trail = tick & half_q;
  // Slave sees edges of the sampled clock; phase picks the sample edge
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire slv_en = block_enable_bit & ~master_enable_bit;
  wire slv_sel = select_mode_high_bit | ~select_mode_low_bit | ~sel_s;
  wire lead_e = (sck_rise & ~clock_polarity_bit) | (sck_fall & clock_polarity_bit);
  wire trail_e = (sck_fall & ~clock_polarity_bit) | (sck_rise & clock_polarity_bit);
  wire slv_samp = slv_en & slv_sel & (clock_phase_bit ? trail_e : lead_e);
  wire slv_shift = slv_en & slv_sel & (clock_phase_bit ? lead_e : trail_e);
  wire m_samp = clock_phase_bit ? mstr_trail : mstr_lead;
  wire m_shift = clock_phase_bit ? mstr_lead : mstr_trail;
  wire samp = master ? m_samp : slv_samp;
  wire in_bit = master ? miso_s : mosi_s;
  wire byte_done = samp & (bitcnt_q == (`SPIMS_LAST_BIT - `SPIMS_ONE_CNT));
  // Phase 0 takes its last bit on a leading edge; the clock must still return to idle
  wire m_end = mstr_trail & (byte_done | last_q);
  wire xfer_end = master ? m_end : byte_done;

  assign busy = active_q;
  assign irq_req = transfer_done_flag | mode_fault_flag | write_collision_flag |
    receive_overrun_flag;
  assign sck_oe_n = ~master;
  assign mosi_oe_n = ~master;
  assign miso_oe_n = ~(slv_en & slv_sel);
  assign select_line_oe_n = ~(master & select_mode_high_bit);

  always @* begin
    fault_ev = master & multi & ~sel_s;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_enable_bit <= 1'b0;
      master_enable_bit <= 1'b0;
      select_mode_high_bit <= 1'b0;
      select_mode_low_bit <= 1'b1;
      transfer_done_flag <= 1'b0;
      mode_fault_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      receive_overrun_flag <= 1'b0;
      select_line_out <= 1'b1;
    end else begin
      if (fault_ev) begin
        block_enable_bit <= 1'b0;
        master_enable_bit <= 1'b0;
      end else begin
        if (block_enable_set) block_enable_bit <= 1'b1;
        else if (block_enable_clr) block_enable_bit <= 1'b0;
        if (master_enable_set) master_enable_bit <= 1'b1;
        else if (master_enable_clr) master_enable_bit <= 1'b0;
      end
      if (select_mode_we) begin
        select_mode_high_bit <= select_mode_wr[1];
        select_mode_low_bit <= select_mode_wr[0];
      end
      select_line_out <= select_mode_low_bit;
      // Hardware set wins over a same-cycle software clear
      if (xfer_end) transfer_done_flag <= 1'b1;
      else if (transfer_done_clr) transfer_done_flag <= 1'b0;
      if (fault_ev) mode_fault_flag <= 1'b1;
      else if (mode_fault_clr) mode_fault_flag <= 1'b0;
      if (wr_strobe & txfull_q) write_collision_flag <= 1'b1;
      else if (write_collision_clr) write_collision_flag <= 1'b0;
      if (byte_done & ~master & rxfull_q) receive_overrun_flag <= 1'b1;
      else if (receive_overrun_clr) receive_overrun_flag <= 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_q <= `SPIMS_ZERO_BYTE;
      txfull_q <= 1'b0;
      shift_q <= `SPIMS_ZERO_BYTE;
      bitcnt_q <= `SPIMS_ZERO_CNT;
      active_q <= 1'b0;
      rxfull_q <= 1'b0;
      rd_data <= `SPIMS_ZERO_BYTE;
      divcnt_q <= {DIV_W{1'b0}};
      half_q <= 1'b0;
      last_q <= 1'b0;
      sck_prev_q <= 1'b0;
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      last_q <= master & active_q & ~m_end & (last_q | byte_done);
      if (wr_strobe & ~txfull_q) begin
        txbuf_q <= wr_data;
        txfull_q <= 1'b1;
      end
      if (rd_strobe) rxfull_q <= 1'b0;
      if (!block_enable_bit) begin
        // A disable or a master load clears a half-received slave byte
        bitcnt_q <= `SPIMS_ZERO_CNT;
        active_q <= 1'b0;
        half_q <= 1'b0;
        sck_out <= clock_polarity_bit;
      end else begin
        if (load) begin
          shift_q <= txbuf_q;
          txfull_q <= 1'b0;
          active_q <= 1'b1;
          bitcnt_q <= `SPIMS_ZERO_CNT;
          half_q <= 1'b0;
          divcnt_q <= div_eff;
          mosi_out <= txbuf_q[7];
          sck_out <= clock_polarity_bit;
        end else if (master & active_q) begin
          divcnt_q <= (divcnt_q == {DIV_W{1'b0}}) ? div_eff : divcnt_q - DIV_ONE;
          if (tick) begin
            half_q <= ~half_q;
            sck_out <= ~sck_out;
          end
        end else if (!master) begin
          sck_out <= clock_polarity_bit;
          if (!slv_en) active_q <= 1'b0;
          // Slave reloads its shifter from the buffer at a byte start only when the buffer is full
          if (slv_en & (bitcnt_q == `SPIMS_ZERO_CNT) & txfull_q & ~active_q) begin
            shift_q <= txbuf_q;
            txfull_q <= 1'b0;
            active_q <= 1'b1;
            miso_out <= txbuf_q[7];
          end
        end
        if (samp) begin
          shift_q <= {shift_q[6:0], in_bit};
          bitcnt_q <= byte_done ? `SPIMS_ZERO_CNT : bitcnt_q + `SPIMS_ONE_CNT;
        end
        if (master ? (m_shift & ~m_end) : (slv_shift & ~byte_done)) begin
          if (master) mosi_out <= shift_q[7];
          else miso_out <= shift_q[7];
        end
        if (xfer_end) begin
          if (master | ~rxfull_q) begin
            rd_data <= byte_done ? {shift_q[6:0], in_bit} : shift_q;
            rxfull_q <= 1'b1;
          end
          active_q <= 1'b0;
          if (master) sck_out <= clock_polarity_bit;
        end
      end
    end
  end
endmodule // spims_core
`default_nettype wire

// [spims_regs.vh]
// Constants for the serial master/slave block with select-line modes
`ifndef SPIMS_REGS_VH
`define SPIMS_REGS_VH
`define SPIMS_CLK_HZ 10000000
`define SPIMS_MAX_RATE_HZ 12500000
`define SPIMS_DIV_MIN 2
`define SPIMS_DIV_W 8
`define SPIMS_BITS 8
`define SPIMS_CNT_W 4
`define SPIMS_NSS_MULTI 2'b01
`define SPIMS_NSS_3WIRE 2'b00
`define SPIMS_ZERO_BYTE 8'h00
`define SPIMS_ZERO_CNT 4'h0
`define SPIMS_ONE_CNT 4'h1
`define SPIMS_LAST_BIT 4'h8
`define SPIMS_ONE_DIV 8'h01
`endif

// [spims_sync.v]
// Two-stage synchroniser for a group of pins
`timescale 1ns/1ns
`default_nettype none
module spims_sync #(
  parameter W = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule // spims_sync
`default_nettype wire

// [spims_core_asserts.sv]
// Port assertions for the serial core
`timescale 1ns/1ns
`default_nettype none
module spims_core_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_strobe,
  input wire logic busy,
  input wire logic mode_fault_flag,
  input wire logic transfer_done_flag,
  input wire logic transfer_done_clr,
  input wire logic master_enable_bit,
  input wire logic block_enable_bit,
  input wire logic select_mode_high_bit,
  input wire logic select_mode_low_bit,
  input wire logic select_line_out,
  input wire logic select_line_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire fw = block_enable_bit && master_enable_bit && select_mode_high_bit;
  wire mst = block_enable_bit && master_enable_bit;
  a_done_holds: assert property (
    transfer_done_flag && !transfer_done_clr |=> transfer_done_flag) else $error("done lost");
  a_fault_disables: assert property (
    $rose(mode_fault_flag) |-> ##[0:1] !master_enable_bit && !block_enable_bit) else $error("on");
  a_fault_mode: assert property (
    $rose(mode_fault_flag) |-> $past(master_enable_bit) && !$past(select_mode_high_bit))
    else $error("fault out of mode");
  a_sel_follow: assert property (
    (fw && $stable(select_mode_low_bit)) [*2] |-> !select_line_oe_n &&
    select_line_out == select_mode_low_bit) else $error("select level");
  a_sel_unused: assert property (
    !select_mode_high_bit [*2] |-> select_line_oe_n) else $error("select driven");
  a_write_starts: assert property (
    wr_strobe && !busy && mst |-> ##[1:2] busy) else $error("no start");
  a_burst_min: assert property (
    $rose(busy) |-> busy [*8]) else $error("transfer too short");
  a_busy_done: assert property (
    $fell(busy) && mst |-> ##[0:1] transfer_done_flag) else $error("no done");
  c_xfer: cover property ($rose(transfer_done_flag));
  c_fault: cover property ($rose(mode_fault_flag));
  c_sel: cover property ($fell(select_line_oe_n));
endmodule // spims_core_asserts
bind spims_core spims_core_asserts u_spims_core_asserts (.ref_clk, .rstn, .wr_strobe, .busy,
  .mode_fault_flag, .transfer_done_flag, .transfer_done_clr, .master_enable_bit,
  .block_enable_bit, .select_mode_high_bit, .select_mode_low_bit, .select_line_out,
  .select_line_oe_n);
`default_nettype wire

// [spims_slave.sv]
// Behavioural serial slave answering the core
`timescale 1ns/1ns
`default_nettype none
module spims_slave (
  input wire logic sck,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic mosi,
  input wire logic load,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic bit_q;
  logic out_q;
  // Polarity folded in, so a rise of k is always the leading edge
  wire k = sck ^ cpol;
  // Phase 0 captures on the lead; phase 1 presents its next bit there
  always @(posedge k) begin
    bit_q <= mosi;
    out_q <= rx[7];
  end
  always @(negedge k or posedge load) begin
    if (load) rx <= tx;
    else rx <= {rx[6:0], cpha ? mosi : bit_q};
  end
  assign miso = cpha ? out_q : rx[7];
endmodule // spims_slave
`default_nettype wire

// [spims_core_tb.sv]
// Self-checking bench for the serial core
`timescale 1ns/1ns
`default_nettype none
module spims_core_tb;
  logic ref_clk, rstn, wr_strobe, select_mode_we, load, t_sck, t_mosi, t_sel;
  logic block_enable_set, block_enable_clr, master_enable_set, transfer_done_clr;
  logic mode_fault_clr, write_collision_clr, receive_overrun_clr;
  logic rd_strobe, clock_phase_bit, clock_polarity_bit;
  logic [7:0] wr_data, stx;
  logic [1:0] select_mode_wr;
  wire block_enable_bit, master_enable_bit, select_mode_high_bit, select_mode_low_bit, busy;
  wire transfer_done_flag, mode_fault_flag, write_collision_flag, receive_overrun_flag, irq_req;
  wire sck_in, sck_out, sck_oe_n, mosi_in, mosi_out, mosi_oe_n, miso_in, miso_out, miso_oe_n;
  wire select_line_in, select_line_out, select_line_oe_n, s_miso;
  wire [7:0] rd_data, srx;
  int num_errors = 0;
  int checks = 0;
  // Polarity and phase, core byte, then slave byte; every clock mode once
  logic [17:0] rows [4] = '{18'h3a53c, 18'h10080, 18'h2ff01, 18'h07e00};
  assign sck_in = sck_oe_n ? t_sck : sck_out;
  assign mosi_in = mosi_oe_n ? t_mosi : mosi_out;
  assign miso_in = miso_oe_n ? s_miso : miso_out;
  assign select_line_in = select_line_oe_n ? t_sel : select_line_out;
  spims_core u_spims_core (.ref_clk, .rstn, .clk_div(8'h03), .block_enable_set,
    .block_enable_clr, .master_enable_set, .master_enable_clr(1'b0), .select_mode_wr,
    .select_mode_we, .clock_phase_bit, .clock_polarity_bit, .wr_data, .wr_strobe,
    .rd_strobe, .transfer_done_clr, .mode_fault_clr, .write_collision_clr,
    .receive_overrun_clr, .block_enable_bit, .master_enable_bit, .select_mode_high_bit,
    .select_mode_low_bit, .transfer_done_flag, .mode_fault_flag, .write_collision_flag,
    .receive_overrun_flag, .irq_req, .rd_data, .busy, .sck_in, .sck_out, .sck_oe_n, .mosi_in,
    .mosi_out, .mosi_oe_n, .miso_in, .miso_out, .miso_oe_n, .select_line_in,
    .select_line_out, .select_line_oe_n);
  spims_slave u_spims_slave (.sck(sck_in), .cpol(clock_polarity_bit), .cpha(clock_phase_bit),
    .mosi(mosi_in), .load, .tx(stx), .miso(s_miso), .rx(srx));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask
  task wr(input logic [7:0] d);
    wr_data = d;
    pulse(wr_strobe);
  endtask
  task sm(input logic [1:0] m);
    select_mode_wr = m;
    pulse(select_mode_we);
    repeat (2) @(negedge ref_clk);
  endtask
  // Bounded wait for the done flag, then clear it
  task wt;
    int n;
    n = 0;
    while (transfer_done_flag !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk(transfer_done_flag, 1);
    pulse(transfer_done_clr);
  endtask
  // External master frame; the clock stands low between frames
  task sb(input logic [7:0] b, input int k);
    for (int i = 7; i > 7 - k; i--) begin
      t_mosi = b[i];
      #400 t_sck = 1'b1;
      #400 t_sck = 1'b0;
    end
    t_mosi = ~t_mosi;
    repeat (8) @(negedge ref_clk);
  endtask
  initial begin
    {rstn, wr_strobe, select_mode_we, load, t_sck, t_mosi, block_enable_set} = '0;
    {block_enable_clr, master_enable_set, transfer_done_clr, mode_fault_clr} = '0;
    {write_collision_clr, receive_overrun_clr} = '0;
    {rd_strobe, clock_phase_bit, clock_polarity_bit} = '0;
    {wr_data, stx, select_mode_wr, t_sel} = 19'h1;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({select_mode_high_bit, select_mode_low_bit, select_line_oe_n}, 8'h03);
    chk({transfer_done_flag, mode_fault_flag, master_enable_bit, block_enable_bit}, 0);
    pulse(block_enable_set);
    pulse(master_enable_set);
    chk(master_enable_bit, 1);
    $display("reset test done");
    for (int v = 2; v < 4; v++) begin
      sm(v[1:0]);
      chk({select_line_oe_n, select_line_out}, v[0]);
    end
    sm(2'b00);
    chk(select_line_oe_n, 1);
    foreach (rows[i]) begin
      // Clock mode changes only while the block is disabled
      pulse(block_enable_clr);
      {clock_polarity_bit, clock_phase_bit} = rows[i][17:16];
      pulse(block_enable_set);
      stx = rows[i][7:0];
      pulse(load);
      wr(rows[i][15:8]);
      wt();
      chk(rd_data, rows[i][7:0]);
      chk(srx, rows[i][15:8]);
    end
    $display("table test done");
    wr(8'h11);
    repeat (4) @(negedge ref_clk);
    wr(8'h22);
    wr(8'h33);
    chk(write_collision_flag, 1);
    pulse(write_collision_clr);
    wt();
    wt();
    // A third transfer would finish well inside this gap
    repeat (100) @(negedge ref_clk);
    chk({busy, transfer_done_flag, write_collision_flag}, 0);
    $display("queue test done");
    sm(2'b01);
    t_sel = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({mode_fault_flag, irq_req, master_enable_bit, block_enable_bit}, 8'h0c);
    t_sel = 1'b1;
    pulse(mode_fault_clr);
    repeat (20) @(negedge ref_clk);
    chk({mode_fault_flag, master_enable_bit, block_enable_bit}, 0);
    $display("fault test done");
    sm(2'b00);
    pulse(block_enable_set);
    // Master bytes left the receive buffer full; mark them read
    pulse(rd_strobe);
    sb(8'hf0, 4);
    pulse(block_enable_clr);
    pulse(block_enable_set);
    sb(8'hc5, 8);
    chk(rd_data, 8'hc5);
    sb(8'h3a, 8);
    chk(receive_overrun_flag, 1);
    chk(rd_data, 8'hc5);
    pulse(receive_overrun_clr);
    chk(receive_overrun_flag, 0);
    $display("slave test done");
    report_and_stop;
  end
  initial begin
    #1000000;
    num_errors++;
    report_and_stop;
  end
endmodule // spims_core_tb
`default_nettype wire
